//--- scm_pkg.sv
// Package for the signal conflict fault monitor: register map, field
// layouts, reset values, timing constants and carrier types.
// Assumes a 200 MHz mclk and a synchronous active-high reset.
package scm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH    = 18;
  localparam int unsigned NUM_PHASE = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_REDEN    = 8'h04;
  localparam logic [7:0] OFS_DUALEN   = 8'h08;
  localparam logic [7:0] OFS_CLREN    = 8'h0C;
  localparam logic [7:0] OFS_YINH     = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_FAULTCH  = 8'h18;
  localparam logic [7:0] OFS_LAMPS    = 8'h1C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [9:0]  CTRL_RST  = 10'h000;
  localparam logic [17:0] CHEN_RST  = 18'h0_0000;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_REDFAIL   = 0;
  localparam int unsigned ST_CLEAR     = 1;
  localparam int unsigned ST_DUAL      = 2;
  localparam int unsigned ST_CONFIG    = 3;
  localparam int unsigned ST_WDT       = 4;
  localparam int unsigned ST_CABLE     = 5;
  localparam int unsigned ST_FLASHRATE = 6;
  localparam int unsigned ST_BROWN     = 7;
  localparam int unsigned ST_FLASHIVL  = 8;
  localparam int unsigned ST_TRIGGERED = 9;
  localparam int unsigned NUM_ST       = 10;

  // ----------------------------------------------------------------
  // Timing, in ms, and watchdog transition count; the tick is derived from the clock period
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0]  LAMP_ON_MS    = 10'd500;
  localparam logic [9:0]  AUX_ON_MS     = 10'd550;
  localparam logic [11:0] REDFAIL_A_MS  = 12'd1000;
  localparam logic [11:0] REDFAIL_B_MS  = 12'd1500;
  localparam logic [11:0] YEL_MIN_MS    = 12'd2700;
  localparam logic [11:0] DUAL_MS       = 12'd500;
  localparam logic [11:0] FLASHRATE_MS  = 12'd1600;
  localparam logic [11:0] CFG_HOLD_MS   = 12'd3000;
  localparam logic [13:0] IVL_MIN_MS    = 14'd6000;
  localparam logic [13:0] WDT_LIMIT_MS  = 14'd10000;
  localparam logic [13:0] IVL_MAX_MS    = 14'd16000;
  localparam logic [8:0]  BLINK4_MS     = 9'd125;
  localparam logic [8:0]  BLINK2_MS     = 9'd250;
  localparam logic [2:0]  WD_TRANS_MIN  = 3'd5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FLASH_IVL, RUN, BROWN} scm_mode_type;

  typedef struct packed {
    logic [17:0] green;
    logic [17:0] yellow;
    logic [17:0] red;
  } scm_lamp_type;

  typedef struct packed {
    logic       relayInvert;    // 9
    logic       flashRateOff;   // 8
    logic [3:0] phaseSel;       // 7:4
    logic       reserved;       // 3
    logic       compactMode;    // 2
    logic       gyDualEn;       // 1
    logic       slowController; // 0
  } scm_ctrl_type;

endpackage

//--- scm_monitor.sv
// Signal conflict fault monitor: input qualification, fault latching,
// flash interval and APB register slave.
// Assumes lamp, gate and switch inputs are digital levels synchronous
// to mclk, already sensed by the analog front end.
//
// Overview of operation
// - Jumper inverts relay-common active sense
// - Red cable removal latches fault, forces flash
// - Either inhibit active disables only red-fail
// - Inhibit active after 550 ms high
// - Red on after 500 ms presence
// - Green, yellow on after 500 ms presence
// - Faults except config latch until front or remote reset
// - Red fail after 1000 or 1500 ms
// - Red fail needs enable, gate, no inhibit
// - Yellow after green must last 2.7 s
// - Clearance check gated by enable, inhibit, gate
// - Dual indication over 500 ms triggers
// - Dual checks per channel and global GY
// - Config compared with stored copy, flashes card
// - Config fault cleared by 3 s front hold
// - Brown-out forces flash, power LED blinks 2 Hz
// - Fault mode survives power interruption
// - Flash interval 6-16 s, checks suspended, 4 Hz
// - Interval ends after 5 watchdog transitions
// - No 5 transitions in 10 s: watchdog fault
// - Arrow pair mode and phase selection
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module scm_monitor #(
  parameter int unsigned TICK_DIV = scm_pkg::TICK_CYCLES   // mclk cycles per ms
) (
  input  wire logic                 mclk,          // 200 MHz clock
  input  wire logic                 rst,           // Sync reset, high
  input  wire logic [7:0]           paddr,         // APB address
  input  wire logic                 psel,          // APB select
  input  wire logic                 penable,       // APB enable
  input  wire logic                 pwrite,        // APB write
  input  wire logic [31:0]          pwdata,        // APB write data
  output logic      [31:0]          prdata,        // APB read data
  output logic                      pready,        // APB ready
  output logic                      pslverr,       // APB error
  input  wire scm_pkg::scm_lamp_type lamps,        // Field lamp levels
  input  wire logic [1:0]           auxInhibit,    // Inhibit inputs
  input  wire logic                 redGate,       // Red-monitor gate
  input  wire logic                 relay_common_input, // Relay common level
  input  wire logic                 red_interface_cable, // High while cable seated
  input  wire logic                 watchdog,      // Controller watchdog
  input  wire logic                 lineAboveRestore, // Line over restore level
  input  wire logic                 lineBelowDropout, // Line under drop-out
  input  wire logic                 frontReset,    // Front-panel button
  input  wire logic                 remoteReset,   // External remote reset
  output logic                      faultFlash,    // High: relay to flash
  output logic                      powerLed,      // AC power indicator
  output logic                      cardLed,       // Program card indicator
  output logic [scm_pkg::NUM_ST-1:0] faultLeds,    // Fault indicators
  output logic [17:0]               faultChan      // Channels involved
);

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [17:0] divCnt;
  logic        tick;
  wire         divEnd = (divCnt == 18'(TICK_DIV - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      divCnt <= 18'h0_0000;
      tick   <= 1'b0;
    end else begin
      divCnt <= divEnd ? 18'h0_0000 : divCnt + 18'h0_0001;
      tick   <= divEnd;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  scm_pkg::scm_ctrl_type ctrl;
  logic [17:0] redEn, dualEn, clrEn, yelInh;
  logic [81:0] cfgStored;
  logic [scm_pkg::NUM_ST-1:0] status;

  wire        setup   = psel && !penable;
  wire        wrAcc   = psel && penable && pwrite && pready;
  wire        hitCtrl = (paddr == scm_pkg::OFS_CTRL);
  wire        hitRed  = (paddr == scm_pkg::OFS_REDEN);
  wire        hitDual = (paddr == scm_pkg::OFS_DUALEN);
  wire        hitClr  = (paddr == scm_pkg::OFS_CLREN);
  wire        hitYinh = (paddr == scm_pkg::OFS_YINH);
  wire        hitSt   = (paddr == scm_pkg::OFS_STATUS);
  wire        hitFch  = (paddr == scm_pkg::OFS_FAULTCH);
  wire        hitLmp  = (paddr == scm_pkg::OFS_LAMPS);
  wire        mapped  = hitCtrl | hitRed | hitDual | hitClr | hitYinh | hitSt | hitFch | hitLmp;
  logic [53:0] lampQ;
  wire [31:0] rdMux =
      hitCtrl ? {22'h00_0000, ctrl} :
      hitRed  ? {14'h0000, redEn} :
      hitDual ? {14'h0000, dualEn} :
      hitClr  ? {14'h0000, clrEn} :
      hitYinh ? {14'h0000, yelInh} :
      hitSt   ? {22'h00_0000, status} :
      hitFch  ? {14'h0000, faultChan} :
      hitLmp  ? {14'h0000, lampQ[17:0] | lampQ[35:18] | lampQ[53:36]} :
      32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl   <= scm_pkg::scm_ctrl_type'(scm_pkg::CTRL_RST);
      redEn  <= scm_pkg::CHEN_RST;
      dualEn <= scm_pkg::CHEN_RST;
      clrEn  <= scm_pkg::CHEN_RST;
      yelInh <= scm_pkg::CHEN_RST;
    end else if (wrAcc) begin
      if (hitCtrl) ctrl   <= scm_pkg::scm_ctrl_type'(pwdata[9:0]);
      if (hitRed)  redEn  <= pwdata[17:0];
      if (hitDual) dualEn <= pwdata[17:0];
      if (hitClr)  clrEn  <= pwdata[17:0];
      if (hitYinh) yelInh <= pwdata[17:0];
    end
  end

  // ----------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------
  // Index 0..53 lamps, 54..55 inhibits, 56 red gate
  wire  [56:0] rawIn = {redGate, auxInhibit, lamps};
  logic [56:0] qual;

  genvar gq;
  generate
    for (gq = 0; gq < 57; gq++) begin : g_qual
      localparam logic [9:0] THR = (gq == 54 || gq == 55) ? scm_pkg::AUX_ON_MS
                                                          : scm_pkg::LAMP_ON_MS;
      logic [9:0] cnt;
      always_ff @(posedge mclk) begin
        if (rst) begin
          cnt         <= 10'h000;
          qual[gq]    <= 1'b0;
        end else if (!rawIn[gq]) begin
          // absence drops, short pulse holds state
          cnt         <= 10'h000;
          qual[gq]    <= 1'b0;
        end else if (tick && cnt != THR) begin
          cnt         <= cnt + 10'h001;
        end else if (cnt == THR) begin
          qual[gq]    <= 1'b1;
        end
      end
    end
  endgenerate

  assign lampQ = qual[53:0];
  wire [17:0] redQ = qual[17:0];
  wire [17:0] yelQ = qual[35:18];
  wire [17:0] grnQ = qual[53:36];
  wire inhibit = qual[54] | qual[55];
  wire gateOn  = qual[56];
  wire relayActive = ctrl.relayInvert ? !relay_common_input : relay_common_input;

  // ----------------------------------------------------------------
  // Operating mode and flash interval
  // ----------------------------------------------------------------
  scm_pkg::scm_mode_type mode;
  logic [13:0] ivlMs;
  logic [2:0]  wdTrans;
  logic        wdPrev;
  wire         running = (mode == scm_pkg::RUN);
  wire         wdEdge  = (watchdog != wdPrev) && (wdTrans != scm_pkg::WD_TRANS_MIN);
  // minimum time, transitions and line good
  wire         ivlDone = (ivlMs >= scm_pkg::IVL_MIN_MS) && (wdTrans == scm_pkg::WD_TRANS_MIN)
                         && lineAboveRestore;
  wire         wdtTrip = (mode == scm_pkg::FLASH_IVL) && (ivlMs == scm_pkg::WDT_LIMIT_MS)
                         && (wdTrans != scm_pkg::WD_TRANS_MIN);

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode    <= scm_pkg::FLASH_IVL;
      ivlMs   <= 14'h0000;
      wdTrans <= 3'h0;
      wdPrev  <= 1'b0;
    end else begin
      wdPrev <= watchdog;
      case (mode)
        scm_pkg::FLASH_IVL: begin
          if (wdEdge) wdTrans <= wdTrans + 3'h1;
          if (tick && ivlMs != scm_pkg::IVL_MAX_MS) ivlMs <= ivlMs + 14'h0001;
          if (lineBelowDropout) begin
            mode <= scm_pkg::BROWN;
          end else if (ivlDone || (ivlMs == scm_pkg::IVL_MAX_MS && lineAboveRestore)) begin
            mode <= scm_pkg::RUN;
          end
        end
        scm_pkg::RUN: begin
          if (lineBelowDropout) mode <= scm_pkg::BROWN;
        end
        scm_pkg::BROWN: begin
          if (lineAboveRestore) begin
            mode    <= scm_pkg::FLASH_IVL;
            ivlMs   <= 14'h0000;
            wdTrans <= 3'h0;
          end
        end
        default: mode <= scm_pkg::FLASH_IVL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-channel checks
  // ----------------------------------------------------------------
  // common gating
  wire  chkOn   = running && gateOn && !relayActive;
  wire  [11:0] redLimit = ctrl.slowController ? scm_pkg::REDFAIL_B_MS : scm_pkg::REDFAIL_A_MS;
  logic [17:0] redTrip, clrTrip, dualTrip;

  genvar gc;
  generate
    for (gc = 0; gc < 18; gc++) begin : g_chan
      logic [11:0] redMs, yelMs, dualMs;
      logic        greenSeen, yelTiming;
      wire noneOn  = !redQ[gc] && !yelQ[gc] && !grnQ[gc];
      wire redChk  = chkOn && !inhibit && redEn[gc] && noneOn;
      wire clrChk  = chkOn && clrEn[gc] && !yelInh[gc];
      wire twoOn   = (dualEn[gc] && (redQ[gc] + yelQ[gc] + grnQ[gc] >= 2'd2))
                   || (ctrl.gyDualEn && yelQ[gc] && grnQ[gc]);
      wire dualChk = chkOn && twoOn;
      always_ff @(posedge mclk) begin
        if (rst) begin
          redMs       <= 12'h000;
          yelMs       <= 12'h000;
          dualMs      <= 12'h000;
          greenSeen   <= 1'b0;
          yelTiming   <= 1'b0;
          redTrip[gc] <= 1'b0;
          clrTrip[gc] <= 1'b0;
          dualTrip[gc]<= 1'b0;
        end else begin
          redMs       <= !redChk ? 12'h000 : (tick ? redMs + 12'h001 : redMs);
          redTrip[gc] <= redChk && (redMs >= redLimit);
          dualMs       <= !dualChk ? 12'h000 : (tick ? dualMs + 12'h001 : dualMs);
          dualTrip[gc] <= dualChk && (dualMs >= scm_pkg::DUAL_MS);
          // yellow must follow green long enough
          clrTrip[gc] <= 1'b0;
          if (!clrChk) begin
            greenSeen <= 1'b0;
            yelTiming <= 1'b0;
            yelMs     <= 12'h000;
          end else if (grnQ[gc]) begin
            greenSeen <= 1'b1;
            yelTiming <= 1'b0;
            yelMs     <= 12'h000;
          end else if (greenSeen && yelQ[gc]) begin
            yelTiming <= 1'b1;
            if (tick && yelMs != scm_pkg::YEL_MIN_MS) yelMs <= yelMs + 12'h001;
            if (yelMs == scm_pkg::YEL_MIN_MS) greenSeen <= 1'b0;
          end else if (greenSeen && (yelTiming || redQ[gc])) begin
            clrTrip[gc] <= 1'b1;
            greenSeen   <= 1'b0;
            yelTiming   <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Arrow pair flash-rate check
  // ----------------------------------------------------------------
  logic [3:0] rateTrip;
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_arrow
      localparam int unsigned STD_CH = 8 + gp;
      localparam int unsigned CMP_CH = 2 * gp;
      logic [11:0] onMs;
      wire fyaOn = ctrl.compactMode ? lamps.green[CMP_CH] : lamps.green[STD_CH];
      wire rateChk = running && ctrl.phaseSel[gp] && !ctrl.flashRateOff && fyaOn;
      always_ff @(posedge mclk) begin
        if (rst) begin
          onMs         <= 12'h000;
          rateTrip[gp] <= 1'b0;
        end else begin
          onMs         <= !rateChk ? 12'h000 : (tick ? onMs + 12'h001 : onMs);
          rateTrip[gp] <= rateChk && (onMs >= scm_pkg::FLASHRATE_MS);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Fault latches, resets and indicators
  // ----------------------------------------------------------------
  logic [11:0] holdMs;
  logic        frontPrev;
  logic [8:0]  blinkMs;
  logic        blink4, blink2;
  // Every switch and option register takes part in the comparison
  wire  [81:0] cfgCur   = {ctrl, redEn, dualEn, clrEn, yelInh};
  wire         cfgDiff  = (cfgStored != cfgCur);
  wire         frontHit = frontReset && !frontPrev;
  wire         clrFault = frontHit || remoteReset;
  wire         cfgClear = frontReset && (holdMs == scm_pkg::CFG_HOLD_MS);
  wire         anyLatched = |status[scm_pkg::ST_FLASHRATE:scm_pkg::ST_REDFAIL];

  always_ff @(posedge mclk) begin
    if (rst) begin
      frontPrev <= 1'b0;
      holdMs    <= 12'h000;
      cfgStored <= '0;
      status    <= '0;
      faultChan <= 18'h0_0000;
    end else begin
      frontPrev <= frontReset;
      holdMs    <= !frontReset ? 12'h000
                 : ((tick && holdMs != scm_pkg::CFG_HOLD_MS) ? holdMs + 12'h001 : holdMs);
      // copy stored at power-up and reset
      if (mode == scm_pkg::FLASH_IVL && ivlMs == 14'h0000 && !status[scm_pkg::ST_CONFIG])
        cfgStored <= cfgCur;
      else if (cfgClear)
        cfgStored <= cfgCur;
      if (clrFault) begin
        // Events in the clearing cycle still latch
        status[scm_pkg::ST_FLASHRATE:scm_pkg::ST_REDFAIL] <=
          {|rateTrip, 1'b0, wdtTrip, status[scm_pkg::ST_CONFIG], |dualTrip, |clrTrip, |redTrip};
        faultChan <= redTrip | clrTrip | dualTrip;
      end else begin
        if (|redTrip)  status[scm_pkg::ST_REDFAIL] <= 1'b1;
        if (|clrTrip)  status[scm_pkg::ST_CLEAR]   <= 1'b1;
        if (|dualTrip) status[scm_pkg::ST_DUAL]    <= 1'b1;
        if (|rateTrip) status[scm_pkg::ST_FLASHRATE] <= 1'b1;
        if (wdtTrip)   status[scm_pkg::ST_WDT]     <= 1'b1;
        faultChan <= faultChan | redTrip | clrTrip | dualTrip;
      end
      if (!red_interface_cable)
        status[scm_pkg::ST_CABLE] <= 1'b1;
      else if (clrFault)
        status[scm_pkg::ST_CABLE] <= 1'b0;
      // only the long hold clears it
      if (cfgDiff && !cfgClear)
        status[scm_pkg::ST_CONFIG] <= 1'b1;
      else if (cfgClear)
        status[scm_pkg::ST_CONFIG] <= 1'b0;
      status[scm_pkg::ST_BROWN]     <= (mode == scm_pkg::BROWN);
      status[scm_pkg::ST_FLASHIVL]  <= (mode == scm_pkg::FLASH_IVL);
      status[scm_pkg::ST_TRIGGERED] <= anyLatched;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      blinkMs    <= 9'h000;
      blink4     <= 1'b0;
      blink2     <= 1'b0;
      faultFlash <= 1'b1;
      powerLed   <= 1'b0;
      cardLed    <= 1'b0;
      faultLeds  <= '0;
    end else begin
      if (tick) begin
        blinkMs <= (blinkMs == scm_pkg::BLINK2_MS - 9'h001) ? 9'h000 : blinkMs + 9'h001;
        if (blinkMs == scm_pkg::BLINK4_MS - 9'h001 || blinkMs == scm_pkg::BLINK2_MS - 9'h001)
          blink4 <= !blink4;
        if (blinkMs == scm_pkg::BLINK2_MS - 9'h001)
          blink2 <= !blink2;
      end
      // relay to flash outside normal run
      faultFlash <= !running || anyLatched;
      powerLed   <= (mode == scm_pkg::RUN) ? 1'b1
                  : (mode == scm_pkg::BROWN) ? blink2 : blink4;
      cardLed    <= status[scm_pkg::ST_CONFIG] && blink2;
      faultLeds  <= status;
    end
  end

endmodule // scm_monitor

//--- scm_ctrl_model.sv
// Controller model: drives the watchdog input of the monitor.
// Assumes mclk comes from the bench; toggles every 256 cycles.
`timescale 1ns/1ps
module scm_ctrl_model (
  input  wire logic mclk,    // Clock
  input  wire logic wdEn,    // Toggle enable
  output logic      watchdog // Watchdog level
);
  logic [7:0] cnt;
  initial begin
    cnt = 8'h0;
    watchdog = 1'b0;
  end
  always @(posedge mclk) begin
    cnt <= cnt + 8'h1;
    if (wdEn && cnt == 8'hFF) watchdog <= ~watchdog;
  end
endmodule // scm_ctrl_model

//--- scm_monitor_assertions.sv
// Checker for the conflict fault monitor.
// Bound into scm_monitor; sees its ports only.
`timescale 1ns/1ps
module scm_monitor_assertions (
  input wire logic       mclk,               // Clock
  input wire logic       rst,                // Sync reset
  input wire logic [7:0] paddr,              // APB address
  input wire logic       psel,               // APB select
  input wire logic       penable,            // APB enable
  input wire logic       pready,             // APB ready
  input wire logic       pslverr,            // APB error
  input wire logic       red_interface_cable, // Cable seated
  input wire logic       lineBelowDropout,   // Line low
  input wire logic       frontReset,         // Front button
  input wire logic       remoteReset,        // Remote reset
  input wire logic       faultFlash,         // Relay in flash
  input wire logic       cardLed,            // Program card indicator
  input wire logic [9:0] faultLeds           // Fault indicators
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_rst_flash: assert property (disable iff (1'b0) rst |=> faultFlash)
    else $error("relay left flash during reset");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_apb_err: assert property (psel && !penable && paddr > 8'h1C |=> pslverr)
    else $error("no error on unmapped address");
  a_cable_flash: assert property (!red_interface_cable |-> ##[1:3] faultFlash)
    else $error("cable removal did not flash");
  a_cable_latch: assert property ((faultLeds[5] && !frontReset && !remoteReset) [*3]
    |=> faultLeds[5])
    else $error("cable fault dropped without reset");
  a_config_hold: assert property ((faultLeds[3] && !frontReset) [*3] |=> faultLeds[3])
    else $error("config fault cleared without front hold");
  a_brown_flash: assert property (lineBelowDropout |-> ##[1:3] faultFlash)
    else $error("brownout did not flash");
  a_ivl_flash: assert property (faultLeds[8] |-> $past(faultFlash))
    else $error("interval without flash");
  a_card_led: assert property (cardLed |-> faultLeds[3])
    else $error("card indicator without config fault");
endmodule // scm_monitor_assertions

bind scm_monitor scm_monitor_assertions scm_monitor_assertions_i (.mclk, .rst, .paddr, .psel,
  .penable, .pready, .pslverr, .red_interface_cable, .lineBelowDropout, .frontReset,
  .remoteReset, .faultFlash, .cardLed, .faultLeds);

//--- tb_scm_monitor.sv
// Bench for the conflict fault monitor: APB tasks and field stimulus.
// Assumes scm_pkg, scm_monitor and scm_ctrl_model are compiled first.
`timescale 1ns/1ps
module tb_scm_monitor;
  localparam int TD = 2;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, er, redGate, relayCom, cable;
  logic watchdog, lineAbove, lineBelow, frontReset, remoteReset, wdEn, faultFlash, pwrLed;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] auxInhibit;
  logic [9:0] faultLeds;
  logic [17:0] faultChan;
  scm_pkg::scm_lamp_type lamps;
  int n_fail = 0, samples_checked = 0, cyc = 0;

  scm_monitor #(.TICK_DIV(TD)) scm_monitor_i (.mclk, .rst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .lamps, .auxInhibit, .redGate,
    .relay_common_input(relayCom), .red_interface_cable(cable), .watchdog,
    .lineAboveRestore(lineAbove), .lineBelowDropout(lineBelow), .frontReset, .remoteReset,
    .faultFlash, .powerLed(pwrLed), .cardLed(), .faultLeds, .faultChan);
  scm_ctrl_model scm_ctrl_model_i (.mclk, .wdEn, .watchdog);

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task st(input int b, input logic e);
    apb(1'b0, scm_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[b]}, {31'h0, e});
  endtask
  task ff(input logic e);
    chk({31'h0, faultFlash}, {31'h0, e});
  endtask
  task wms(input int n);
    repeat (n * TD) @(posedge mclk);
  endtask
  task rr;
    remoteReset <= 1'b1;
    repeat (2) @(posedge mclk);
    remoteReset <= 1'b0;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      finish_test;
    end
  end

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {lamps, auxInhibit, redGate, relayCom, cable} = {54'h0, 2'b01, 3'b001};
    {lineAbove, lineBelow, frontReset, remoteReset, wdEn} = 5'b10001;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, scm_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    st(scm_pkg::ST_FLASHIVL, 1'b1);
    wms(5000);
    ff(1'b1);
    wms(1300);
    ff(1'b0);
    chk({31'h0, pwrLed}, 32'h1);
    apb(1'b1, scm_pkg::OFS_REDEN, 32'h1);
    apb(1'b1, scm_pkg::OFS_DUALEN, 32'h1);
    wms(5);
    st(scm_pkg::ST_CONFIG, 1'b1);
    ff(1'b1);
    rr;
    wms(5);
    st(scm_pkg::ST_CONFIG, 1'b1);
    frontReset <= 1'b1;
    wms(2000);
    st(scm_pkg::ST_CONFIG, 1'b1);
    wms(1100);
    frontReset <= 1'b0;
    apb(1'b0, scm_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    redGate <= 1'b1;
    wms(1300);
    st(scm_pkg::ST_REDFAIL, 1'b0);
    auxInhibit <= 2'b00;
    wms(900);
    st(scm_pkg::ST_REDFAIL, 1'b0);
    wms(300);
    st(scm_pkg::ST_REDFAIL, 1'b1);
    apb(1'b0, scm_pkg::OFS_FAULTCH, 32'h0);
    chk(rd, 32'h1);
    lamps.red[0] <= 1'b1;
    wms(600);
    rr;
    wms(1500);
    apb(1'b0, scm_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    lamps.green[0] <= 1'b1;
    wms(900);
    st(scm_pkg::ST_DUAL, 1'b0);
    wms(300);
    st(scm_pkg::ST_DUAL, 1'b1);
    lamps.green[0] <= 1'b0;
    cable <= 1'b0;
    wms(1);
    cable <= 1'b1;
    st(scm_pkg::ST_CABLE, 1'b1);
    {lineBelow, lineAbove} <= 2'b10;
    wms(5);
    st(scm_pkg::ST_BROWN, 1'b1);
    ff(1'b1);
    {lineBelow, lineAbove, wdEn} <= 3'b010;
    wms(5);
    st(scm_pkg::ST_CABLE, 1'b1);
    st(scm_pkg::ST_FLASHIVL, 1'b1);
    wms(10200);
    st(scm_pkg::ST_WDT, 1'b1);
    finish_test;
  end
endmodule // tb_scm_monitor
